// ===== hlcr_top.sv
// Heating loop configuration registers, rate decode and limit handling
// Summary of operation
// - Commanded firing rate comes from the low byte of the command word.
// - Bit 8 set means the rate byte is a fraction, clear means 0.5% steps.
// - Fraction format maps all zeros to no heat and all ones to 996 tenths, just short of max fire.
// - Step format spans 0 to 200, each unit half a percent.
// - Selector 1/2 take a bus rate, 3 and 4 current-loop modulation.
// - Selector 3 switches the burner on sensor versus setpoint hysteresis.
// - Selector 4 switches the burner directly with loop demand.
// - Priority register 0 favours the sequencer, 1 the heating loop.
// - Span water temperatures run -40 to 130 degrees in tenths.
// - Span steam pressures run 0 to 150 psi in tenths.
// - Exchanger limit enable 0 disables and 1 enables the check.
// - Exchanger limit setpoint is the trip temperature in tenths.
// - Trip response 0 locks out, 1 recycles, 2 recycles with a limit.
// - Exchanger delay is 0 to 64800 s, 0xffff means not configured.
// - Retry limit caps recycles caused by exchanger trips.
`timescale 1ns/1ps
module hlcr_top
   import hlcr_pkg::*;
#(
   parameter int CYC_PER_S = HLCR_CYC_PER_S
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // Register access port
   input  wire logic [15:0] reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [15:0] reg_wdata_i,
   output logic      [15:0] reg_rdata_o,
   output logic             reg_ack_o,
   output logic             reg_err_o,
   // Sequencer command
   input  wire logic [15:0] seq_cmd_word_i,
   output logic      [9:0]  seq_rate_o,
   output logic             seq_rate_bad_o,
   // Heating loop
   input  wire logic [9:0]  current_loop_rate_i,
   input  wire logic [15:0] loop_temp_i,
   input  wire logic [15:0] loop_setpoint_i,
   input  wire logic [15:0] loop_hyst_on_i,
   input  wire logic [15:0] loop_hyst_off_i,
   input  wire logic        heating_loop_demand_i,
   output logic      [9:0]  loop_rate_o,
   output logic             loop_rate_bus_o,
   output logic             loop_burner_on_o,
   output logic             loop_has_priority_o,
   output logic             span_cfg_bad_o,
   // Heat exchanger limit
   input  wire logic [15:0] exch_temp_i,
   input  wire logic        lockout_reset_i,
   output logic             exch_trip_o,
   output logic             exch_waiting_o,
   output logic             exch_lockout_o,
   output logic      [15:0] exch_retry_count_o
);

   logic [15:0] regs [HLCR_NREG];
   logic [HLCR_NREG-1:0] hit;

   // Register cells
   genvar gi;
   generate
      for (gi = 0; gi < HLCR_NREG; gi = gi + 1) begin : g_reg
         assign hit[gi] = (reg_addr_i == HLCR_ADDR[gi]);
         hlcr_reg16 #(.RST_VAL(HLCR_RST[gi])) u_reg (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .load_i     (reg_wr_i & hit[gi]),
            .d_i        (reg_wdata_i),
            .q_o        (regs[gi])
         );
      end
   endgenerate

   // Read path
   logic [15:0] rdata_ff;
   logic        ack_ff;
   logic        err_ff;
   logic [15:0] nxt_rdata;
   logic        nxt_ack;
   logic        nxt_err;
   logic        in_range;

   always_comb begin
      in_range  = (reg_addr_i >= HLCR_A_FIRST) && (reg_addr_i <= HLCR_A_LAST);
      nxt_ack   = (reg_rd_i | reg_wr_i) & in_range;
      nxt_err   = (reg_rd_i | reg_wr_i) & ~in_range;
      nxt_rdata = rdata_ff;
      if (reg_rd_i) begin
         nxt_rdata = 16'h0000;
         for (int i = 0; i < HLCR_NREG; i++) begin
            if (hit[i]) begin
               nxt_rdata = regs[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_ff <= 16'h0000;
         ack_ff   <= 1'b0;
         err_ff   <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         ack_ff   <= nxt_ack;
         err_ff   <= nxt_err;
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign reg_ack_o   = ack_ff;
   assign reg_err_o   = err_ff;

   // Rate byte to tenths of a percent
   function automatic logic [9:0] rate_tenths(input logic [7:0] b,
                                              input logic frac);
      logic [17:0] f;
      logic [10:0] s;
      f = 18'(b) * HLCR_FULL_SCALE;
      s = 11'(b) * HLCR_STEP_MULT;
      if (frac) begin
         rate_tenths = f[17:HLCR_FRAC_SHIFT];
      end else if (b > HLCR_STEP_MAX) begin
         rate_tenths = 10'(HLCR_FULL_SCALE);
      end else begin
         rate_tenths = s[9:0];
      end
   endfunction

   // Rate decode group
   logic [9:0]  seq_rate_ff;
   logic        seq_bad_ff;
   logic [9:0]  loop_rate_ff;
   logic        loop_bus_ff;
   logic        prio_ff;
   logic        span_bad_ff;
   logic [9:0]  nxt_seq_rate;
   logic        nxt_seq_bad;
   logic [9:0]  nxt_loop_rate;
   logic        nxt_loop_bus;
   logic        nxt_prio;
   logic        nxt_span_bad;
   logic [15:0] src;

   always_comb begin
      src = regs[HLCR_I_SRC_SEL];
      nxt_seq_rate = rate_tenths(seq_cmd_word_i[HLCR_RATE_MSB:0],
                                 seq_cmd_word_i[HLCR_FMT_BIT]);
      nxt_seq_bad  = ~seq_cmd_word_i[HLCR_FMT_BIT] &&
                     (seq_cmd_word_i[HLCR_RATE_MSB:0] > HLCR_STEP_MAX);
      // Bus rate only for bus sources
      nxt_loop_bus  = (src == HLCR_SRC_BUS_FRAC) ||
                      (src == HLCR_SRC_BUS_STEP);
      if (nxt_loop_bus) begin
         nxt_loop_rate = rate_tenths(regs[HLCR_I_BUS_RATE][HLCR_RATE_MSB:0],
                                     src == HLCR_SRC_BUS_FRAC);
      end else begin
         nxt_loop_rate = current_loop_rate_i;
      end
      nxt_prio = (regs[HLCR_I_PRIORITY] == HLCR_PRIO_LOOP);
      nxt_span_bad =
         ($signed(regs[HLCR_I_LO_TEMP]) < HLCR_TEMP_MIN) ||
         ($signed(regs[HLCR_I_LO_TEMP]) > HLCR_TEMP_MAX) ||
         ($signed(regs[HLCR_I_HI_TEMP]) < HLCR_TEMP_MIN) ||
         ($signed(regs[HLCR_I_HI_TEMP]) > HLCR_TEMP_MAX) ||
         (regs[HLCR_I_LO_PRESS] > HLCR_PRESS_MAX) ||
         (regs[HLCR_I_HI_PRESS] > HLCR_PRESS_MAX);
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         seq_rate_ff  <= 10'h000;
         seq_bad_ff   <= 1'b0;
         loop_rate_ff <= 10'h000;
         loop_bus_ff  <= 1'b0;
         prio_ff      <= 1'b0;
         span_bad_ff  <= 1'b0;
      end else begin
         seq_rate_ff  <= nxt_seq_rate;
         seq_bad_ff   <= nxt_seq_bad;
         loop_rate_ff <= nxt_loop_rate;
         loop_bus_ff  <= nxt_loop_bus;
         prio_ff      <= nxt_prio;
         span_bad_ff  <= nxt_span_bad;
      end
   end

   assign seq_rate_o          = seq_rate_ff;
   assign seq_rate_bad_o      = seq_bad_ff;
   assign loop_rate_o         = loop_rate_ff;
   assign loop_rate_bus_o     = loop_bus_ff;
   assign loop_has_priority_o = prio_ff;
   assign span_cfg_bad_o      = span_bad_ff;

   // Exchanger limit group
   hlcr_xl_state_t xl_ff;
   hlcr_xl_state_t nxt_xl;
   logic [31:0]    tick_cnt_ff;
   logic [31:0]    nxt_tick_cnt;
   logic [15:0]    delay_ff;
   logic [15:0]    nxt_delay;
   logic [15:0]    retry_ff;
   logic [15:0]    nxt_retry;
   logic           trip_ff;
   logic           nxt_trip;
   logic           trip_now;
   logic           sec_tick;
   logic [15:0]    resp;
   logic [15:0]    dly;

   always_comb begin
      resp = regs[HLCR_I_XL_RESP];
      dly  = regs[HLCR_I_XL_DELAY];
      trip_now = (regs[HLCR_I_XL_ENABLE] == HLCR_XL_ON) &&
                 ($signed(exch_temp_i) >= $signed(regs[HLCR_I_XL_SETPT]));
      nxt_trip     = trip_now;
      sec_tick     = (tick_cnt_ff == 32'(CYC_PER_S - 1));
      nxt_tick_cnt = sec_tick ? 32'h0 : tick_cnt_ff + 32'h1;
      nxt_xl       = xl_ff;
      nxt_delay    = delay_ff;
      nxt_retry    = retry_ff;
      case (xl_ff)
         HLCR_XL_IDLE: begin
            nxt_tick_cnt = 32'h0;
            if (trip_now) begin
               if (resp == HLCR_RESP_RECYCLE && dly != HLCR_NOT_CONFIG &&
                   dly <= HLCR_DELAY_MAX) begin
                  nxt_xl    = HLCR_XL_WAIT;
                  nxt_delay = dly;
               end else if (resp == HLCR_RESP_RETRY &&
                            dly != HLCR_NOT_CONFIG &&
                            dly <= HLCR_DELAY_MAX &&
                            retry_ff < regs[HLCR_I_XL_RETRY]) begin
                  nxt_xl    = HLCR_XL_WAIT;
                  nxt_delay = dly;
                  nxt_retry = retry_ff + 16'h0001;
               end else begin
                  nxt_xl = HLCR_XL_LOCK;
               end
            end
         end
         HLCR_XL_WAIT: begin
            if (delay_ff == 16'h0000) begin
               nxt_xl = HLCR_XL_IDLE;
            end else if (sec_tick) begin
               nxt_delay = delay_ff - 16'h0001;
            end
         end
         HLCR_XL_LOCK: begin
            nxt_tick_cnt = 32'h0;
            if (lockout_reset_i) begin
               nxt_xl    = HLCR_XL_IDLE;
               nxt_retry = 16'h0000;
            end
         end
         default: begin
            nxt_xl = HLCR_XL_LOCK;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         xl_ff       <= HLCR_XL_IDLE;
         tick_cnt_ff <= 32'h0;
         delay_ff    <= 16'h0000;
         retry_ff    <= 16'h0000;
         trip_ff     <= 1'b0;
      end else begin
         xl_ff       <= nxt_xl;
         tick_cnt_ff <= nxt_tick_cnt;
         delay_ff    <= nxt_delay;
         retry_ff    <= nxt_retry;
         trip_ff     <= nxt_trip;
      end
   end

   assign exch_trip_o        = trip_ff;
   assign exch_waiting_o     = (xl_ff == HLCR_XL_WAIT);
   assign exch_lockout_o     = (xl_ff == HLCR_XL_LOCK);
   assign exch_retry_count_o = retry_ff;

   // Burner switching group
   logic               burner_ff;
   logic               nxt_burner;
   logic               sens_on_ff;
   logic               nxt_sens_on;
   logic signed [17:0] t;
   logic signed [17:0] on_lvl;
   logic signed [17:0] off_lvl;
   logic               permit;

   always_comb begin
      t       = 18'(signed'(loop_temp_i));
      on_lvl  = 18'(signed'(loop_setpoint_i)) - 18'(loop_hyst_on_i);
      off_lvl = 18'(signed'(loop_setpoint_i)) + 18'(loop_hyst_off_i);
      nxt_sens_on = sens_on_ff;
      if (t <= on_lvl) begin
         nxt_sens_on = 1'b1;
      end else if (t >= off_lvl) begin
         nxt_sens_on = 1'b0;
      end
      permit = (xl_ff == HLCR_XL_IDLE) && !trip_now;
      if (src == HLCR_SRC_LOOP_DMND) begin
         nxt_burner = heating_loop_demand_i && permit;
      end else begin
         nxt_burner = heating_loop_demand_i && nxt_sens_on && permit;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         burner_ff  <= 1'b0;
         sens_on_ff <= 1'b0;
      end else begin
         burner_ff  <= nxt_burner;
         sens_on_ff <= nxt_sens_on;
      end
   end

   assign loop_burner_on_o = burner_ff;

endmodule // hlcr_top

// ===== hlcr_pkg.sv
// Constants shared by the heating loop configuration register bank
package hlcr_pkg;

   // Register addresses
   localparam logic [15:0] HLCR_A_SRC_SEL    = 16'h0244;
   localparam logic [15:0] HLCR_A_BUS_RATE   = 16'h0245;
   localparam logic [15:0] HLCR_A_PRIORITY   = 16'h0246;
   localparam logic [15:0] HLCR_A_LO_TEMP    = 16'h0247;
   localparam logic [15:0] HLCR_A_HI_TEMP    = 16'h0248;
   localparam logic [15:0] HLCR_A_LO_PRESS   = 16'h0249;
   localparam logic [15:0] HLCR_A_HI_PRESS   = 16'h024a;
   localparam logic [15:0] HLCR_A_STEAM_SP   = 16'h024b;
   localparam logic [15:0] HLCR_A_STANDBY    = 16'h024c;
   localparam logic [15:0] HLCR_A_XL_ENABLE  = 16'h0250;
   localparam logic [15:0] HLCR_A_XL_SETPT   = 16'h0251;
   localparam logic [15:0] HLCR_A_XL_RESP    = 16'h0252;
   localparam logic [15:0] HLCR_A_XL_DELAY   = 16'h0253;
   localparam logic [15:0] HLCR_A_XL_RETRY   = 16'h0254;
   localparam logic [15:0] HLCR_A_FIRST      = 16'h0244;
   localparam logic [15:0] HLCR_A_LAST       = 16'h0254;

   // Register slots
   localparam int HLCR_NREG = 14;
   localparam int HLCR_I_SRC_SEL   = 0;
   localparam int HLCR_I_BUS_RATE  = 1;
   localparam int HLCR_I_PRIORITY  = 2;
   localparam int HLCR_I_LO_TEMP   = 3;
   localparam int HLCR_I_HI_TEMP   = 4;
   localparam int HLCR_I_LO_PRESS  = 5;
   localparam int HLCR_I_HI_PRESS  = 6;
   localparam int HLCR_I_STEAM_SP  = 7;
   localparam int HLCR_I_STANDBY   = 8;
   localparam int HLCR_I_XL_ENABLE = 9;
   localparam int HLCR_I_XL_SETPT  = 10;
   localparam int HLCR_I_XL_RESP   = 11;
   localparam int HLCR_I_XL_DELAY  = 12;
   localparam int HLCR_I_XL_RETRY  = 13;

   localparam logic [15:0] HLCR_ADDR [HLCR_NREG] = '{
      HLCR_A_SRC_SEL, HLCR_A_BUS_RATE, HLCR_A_PRIORITY, HLCR_A_LO_TEMP,
      HLCR_A_HI_TEMP, HLCR_A_LO_PRESS, HLCR_A_HI_PRESS, HLCR_A_STEAM_SP,
      HLCR_A_STANDBY, HLCR_A_XL_ENABLE, HLCR_A_XL_SETPT, HLCR_A_XL_RESP,
      HLCR_A_XL_DELAY, HLCR_A_XL_RETRY};

   // Reset values
   localparam logic [15:0] HLCR_RST_ZERO    = 16'h0000;
   localparam logic [15:0] HLCR_NOT_CONFIG  = 16'hffff;
   localparam logic [15:0] HLCR_RST [HLCR_NREG] = '{
      HLCR_RST_ZERO, HLCR_RST_ZERO, HLCR_RST_ZERO, HLCR_RST_ZERO,
      HLCR_RST_ZERO, HLCR_RST_ZERO, HLCR_RST_ZERO, HLCR_RST_ZERO,
      HLCR_RST_ZERO, HLCR_RST_ZERO, HLCR_RST_ZERO, HLCR_RST_ZERO,
      HLCR_NOT_CONFIG, HLCR_RST_ZERO};

   // Command word fields
   localparam int HLCR_RATE_MSB    = 7;
   localparam int HLCR_FMT_BIT     = 8;

   // Rate source selector codes
   localparam logic [15:0] HLCR_SRC_BUS_FRAC   = 16'h0001;
   localparam logic [15:0] HLCR_SRC_BUS_STEP   = 16'h0002;
   localparam logic [15:0] HLCR_SRC_LOOP_SENS  = 16'h0003;
   localparam logic [15:0] HLCR_SRC_LOOP_DMND  = 16'h0004;

   // Priority, enable and response codes
   localparam logic [15:0] HLCR_PRIO_LOOP      = 16'h0001;
   localparam logic [15:0] HLCR_XL_ON          = 16'h0001;
   localparam logic [15:0] HLCR_RESP_LOCKOUT   = 16'h0000;
   localparam logic [15:0] HLCR_RESP_RECYCLE   = 16'h0001;
   localparam logic [15:0] HLCR_RESP_RETRY     = 16'h0002;

   // Rate scaling, output in tenths of a percent
   localparam logic [17:0] HLCR_FULL_SCALE     = 18'h003e8;
   localparam logic [10:0] HLCR_STEP_MULT      = 11'h005;
   localparam logic [7:0]  HLCR_STEP_MAX       = 8'hc8;
   localparam int          HLCR_FRAC_SHIFT     = 8;

   // Value ranges, temperatures and pressures in tenths, delay in seconds
   localparam logic signed [15:0] HLCR_TEMP_MIN  = -16'sd400;
   localparam logic signed [15:0] HLCR_TEMP_MAX  = 16'sd1300;
   localparam logic [15:0]        HLCR_PRESS_MAX = 16'h05dc;
   localparam logic [15:0]        HLCR_DELAY_MAX = 16'hfd20;

   // Timing
   localparam longint HLCR_CLK_HZ    = 25000000;
   localparam longint HLCR_TICK_S    = 1;
   localparam int     HLCR_CYC_PER_S = int'(HLCR_CLK_HZ * HLCR_TICK_S);

   typedef enum logic [1:0] {
      HLCR_XL_IDLE = 2'b00,
      HLCR_XL_WAIT = 2'b01,
      HLCR_XL_LOCK = 2'b11
   } hlcr_xl_state_t;

endpackage

// ===== hlcr_reg16.sv
// One 16-bit configuration register with load strobe
`timescale 1ns/1ps
module hlcr_reg16 #(
   parameter logic [15:0] RST_VAL = 16'h0000
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // Load port
   input  wire logic        load_i,
   input  wire logic [15:0] d_i,
   // Stored value
   output logic      [15:0] q_o
);

   logic [15:0] val_ff;
   logic [15:0] nxt_val;

   always_comb begin
      nxt_val = load_i ? d_i : val_ff;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         val_ff <= RST_VAL;
      end else begin
         val_ff <= nxt_val;
      end
   end

   assign q_o = val_ff;

endmodule // hlcr_reg16

// ===== hlcr_checker.sv
// Port-level assertions for the heating loop register bank
`timescale 1ns/1ps
module hlcr_checker
   import hlcr_pkg::*;
#(
   parameter int CYC_PER_S = 4
) (
   // Clock and reset
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   // Register port
   input wire logic [15:0] reg_addr_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        reg_ack_o,
   input wire logic        reg_err_o,
   // Rate and burner
   input wire logic [15:0] seq_cmd_word_i,
   input wire logic [9:0]  seq_rate_o,
   input wire logic        seq_rate_bad_o,
   input wire logic [9:0]  current_loop_rate_i,
   input wire logic        heating_loop_demand_i,
   input wire logic [9:0]  loop_rate_o,
   input wire logic        loop_rate_bus_o,
   input wire logic        loop_burner_on_o,
   // Exchanger limit
   input wire logic        lockout_reset_i,
   input wire logic        exch_waiting_o,
   input wire logic        exch_lockout_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic acc;
   logic in_map;
   assign acc = reg_rd_i || reg_wr_i;
   assign in_map = reg_addr_i >= HLCR_A_FIRST && reg_addr_i <= HLCR_A_LAST;

   a_ack_mapped: assert property (acc && in_map |=> reg_ack_o && !reg_err_o)
      else $error("no ack for mapped access");
   a_err_unmapped: assert property (acc && !in_map |=>
      reg_err_o && !reg_ack_o &&
      (!$past(reg_rd_i) || reg_rdata_o == 16'h0000))
      else $error("no error for unmapped access");
   a_reserved_zero: assert property (reg_rd_i && reg_addr_i >= 16'h024d &&
      reg_addr_i <= 16'h024f |=> reg_rdata_o == 16'h0000)
      else $error("reserved slot not zero");
   a_step_rate: assert property (!seq_cmd_word_i[8] &&
      seq_cmd_word_i[7:0] <= 8'hc8 |=>
      seq_rate_o == 10'($past(seq_cmd_word_i[7:0])) * 10'h005 &&
      !seq_rate_bad_o)
      else $error("step rate wrong");
   a_frac_rate: assert property (seq_cmd_word_i[8] |=>
      18'(seq_rate_o) ==
      (18'($past(seq_cmd_word_i[7:0])) * 18'h003e8) >> 8)
      else $error("fraction rate wrong");
   a_step_clamp: assert property (!seq_cmd_word_i[8] &&
      seq_cmd_word_i[7:0] > 8'hc8 |=> seq_rate_o == 10'h3e8 && seq_rate_bad_o)
      else $error("step clamp wrong");
   a_loop_rate: assert property (!loop_rate_bus_o && !$past(rst_i) |->
      loop_rate_o == $past(current_loop_rate_i))
      else $error("loop rate not from current loop");
   a_no_demand: assert property (!heating_loop_demand_i |=> !loop_burner_on_o)
      else $error("burner on without demand");
   a_hold_burner: assert property (exch_lockout_o || exch_waiting_o |=>
      !loop_burner_on_o) else $error("burner on in limit");
   a_lock_holds: assert property (exch_lockout_o && !lockout_reset_i |=>
      exch_lockout_o) else $error("lockout left early");

   c_err: cover property (reg_err_o);
   c_wait: cover property (exch_waiting_o);
   c_lock: cover property ($rose(exch_lockout_o));
endmodule // hlcr_checker

bind hlcr_top hlcr_checker #(.CYC_PER_S(CYC_PER_S)) u_chk (.*);

// ===== hlcr_master.sv
// Bus master model that reaches the register bank
`timescale 1ns/1ps
module hlcr_master (
   // Clock
   input  wire logic        core_clk_i,
   // Answer from the bank
   input  wire logic [15:0] reg_rdata_i,
   input  wire logic        reg_ack_i,
   input  wire logic        reg_err_i,
   // Request to the bank
   output logic      [15:0] reg_addr_o,
   output logic             reg_wr_o,
   output logic             reg_rd_o,
   output logic      [15:0] reg_wdata_o
);
   initial begin
      reg_addr_o = 16'h0000;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 16'h0000;
   end
   task automatic access(input logic wr, input logic [15:0] a,
                         input logic [15:0] d, output logic [15:0] q,
                         output logic ok, output logic er);
      int n;
      @(posedge core_clk_i);
      #1;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = wr;
      reg_rd_o = !wr;
      @(posedge core_clk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      // Released lines show the inverse
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
      n = 0;
      while (reg_ack_i !== 1'b1 && reg_err_i !== 1'b1 && n < 4) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      q = reg_rdata_i;
      ok = reg_ack_i;
      er = reg_err_i;
   endtask
endmodule // hlcr_master

// ===== hlcr_top_bench.sv
// Self-checking bench for the heating loop register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module hlcr_top_bench;
   import hlcr_pkg::*;
   localparam int CPS = 4;
   logic        core_clk_i, rst_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o;
   logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, seq_cmd_word_i;
   logic [9:0]  seq_rate_o, current_loop_rate_i, loop_rate_o;
   logic [15:0] loop_temp_i, loop_setpoint_i, loop_hyst_on_i;
   logic [15:0] loop_hyst_off_i, exch_temp_i, exch_retry_count_o;
   logic        seq_rate_bad_o, heating_loop_demand_i, loop_rate_bus_o;
   logic        loop_burner_on_o, loop_has_priority_o, span_cfg_bad_o;
   logic        lockout_reset_i, exch_trip_o, exch_waiting_o, exch_lockout_o;
   int          fails, cmp_count, n;
   logic [15:0] cw [6] = '{16'h0100, 16'h00c8, 16'h0065, 16'h01ff,
                           16'h0180, 16'h00c9};
   logic [9:0]  ew [6] = '{10'h000, 10'h3e8, 10'h1f9, 10'h3e4,
                           10'h1f4, 10'h3e8};

   hlcr_top #(.CYC_PER_S(CPS)) u_dut (.*);
   hlcr_master u_master (
      .core_clk_i  (core_clk_i),
      .reg_rdata_i (reg_rdata_o),
      .reg_ack_i   (reg_ack_o),
      .reg_err_i   (reg_err_o),
      .reg_addr_o  (reg_addr_i),
      .reg_wr_o    (reg_wr_i),
      .reg_rd_o    (reg_rd_i),
      .reg_wdata_o (reg_wdata_i)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] q;
      logic ok, er;
      u_master.access(1'b1, a, d, q, ok, er);
      `CHK("write ack", 1'b1, ok)
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e,
                     input logic eo);
      logic [15:0] q;
      logic ok, er;
      u_master.access(1'b0, a, 16'h0000, q, ok, er);
      `CHK("read ack", eo, ok)
      `CHK("read err", !eo, er)
      `CHK("read data", e, q)
   endtask
   // Bounded wait on the exchanger state
   task automatic wait_state(input logic w, input logic l);
      n = 0;
      while (!(exch_waiting_o === w && exch_lockout_o === l) && n < 40) begin
         cyc(1);
         n++;
      end
      if (n >= 40) begin
         fails++;
         complete_run();
      end
   endtask

   initial begin
      {fails, cmp_count} = 0;
      rst_i = 1'b1;
      seq_cmd_word_i = 16'h0000;
      current_loop_rate_i = 10'h123;
      loop_temp_i = 16'h02bc;
      loop_setpoint_i = 16'h0258;
      loop_hyst_on_i = 16'h0032;
      loop_hyst_off_i = 16'h0032;
      heating_loop_demand_i = 1'b0;
      exch_temp_i = 16'h02bc;
      lockout_reset_i = 1'b0;
      cyc(5);
      rst_i = 1'b0;
      for (int i = 0; i < HLCR_NREG; i++) rd(HLCR_ADDR[i], HLCR_RST[i], 1);
      for (int i = 0; i < HLCR_NREG; i++) wr(HLCR_ADDR[i], 16'ha5c0 + 16'(i));
      for (int i = 0; i < HLCR_NREG; i++) rd(HLCR_ADDR[i], 16'ha5c0 + 16'(i), 1);
      wr(16'h024e, 16'h1234);
      rd(16'h024e, 16'h0000, 1);
      rd(16'h0255, 16'h0000, 0);
      rd(16'h0243, 16'h0000, 0);
      for (int i = 0; i < 6; i++) begin
         seq_cmd_word_i = cw[i];
         cyc(2);
         `CHK("seq rate", ew[i], seq_rate_o)
         `CHK("seq bad", i == 5, seq_rate_bad_o)
      end
      wr(HLCR_A_SRC_SEL, HLCR_SRC_BUS_FRAC);
      wr(HLCR_A_BUS_RATE, 16'h0080);
      cyc(2);
      `CHK("bus frac", 10'h1f4, loop_rate_o)
      `CHK("bus flag", 1'b1, loop_rate_bus_o)
      wr(HLCR_A_SRC_SEL, HLCR_SRC_BUS_STEP);
      wr(HLCR_A_BUS_RATE, 16'h0164);
      cyc(2);
      `CHK("bus step", 10'h1f4, loop_rate_o)
      wr(HLCR_A_SRC_SEL, HLCR_SRC_LOOP_DMND);
      heating_loop_demand_i = 1'b1;
      cyc(2);
      `CHK("loop rate", 10'h123, loop_rate_o)
      `CHK("burner dmnd", 1'b1, loop_burner_on_o)
      heating_loop_demand_i = 1'b0;
      cyc(2);
      `CHK("burner off", 1'b0, loop_burner_on_o)
      heating_loop_demand_i = 1'b1;
      wr(HLCR_A_SRC_SEL, HLCR_SRC_LOOP_SENS);
      cyc(2);
      `CHK("sensor high", 1'b0, loop_burner_on_o)
      loop_temp_i = 16'h01f4;
      cyc(2);
      `CHK("sensor low", 1'b1, loop_burner_on_o)
      loop_temp_i = 16'h026c;
      cyc(2);
      `CHK("sensor band", 1'b1, loop_burner_on_o)
      loop_temp_i = 16'h0294;
      cyc(2);
      `CHK("sensor over", 1'b0, loop_burner_on_o)
      for (int i = 0; i < 2; i++) begin
         wr(HLCR_A_PRIORITY, 16'(1 - i));
         cyc(2);
         `CHK("priority", 1'(1 - i), loop_has_priority_o)
      end
      wr(HLCR_A_LO_TEMP, 16'hfe6f);
      wr(HLCR_A_HI_TEMP, 16'h0514);
      wr(HLCR_A_LO_PRESS, 16'h0000);
      wr(HLCR_A_HI_PRESS, 16'h05dc);
      cyc(2);
      `CHK("span temp", 1'b1, span_cfg_bad_o)
      wr(HLCR_A_LO_TEMP, 16'hfe70);
      cyc(2);
      `CHK("span ok", 1'b0, span_cfg_bad_o)
      wr(HLCR_A_HI_PRESS, 16'h05dd);
      cyc(2);
      `CHK("span press", 1'b1, span_cfg_bad_o)
      wr(HLCR_A_XL_SETPT, 16'h0320);
      wr(HLCR_A_XL_RESP, HLCR_RESP_LOCKOUT);
      wr(HLCR_A_XL_ENABLE, HLCR_XL_ON);
      exch_temp_i = 16'h0320;
      wait_state(0, 1);
      `CHK("trip", 1'b1, exch_trip_o)
      exch_temp_i = 16'h02bc;
      lockout_reset_i = 1'b1;
      cyc(1);
      lockout_reset_i = 1'b0;
      wait_state(0, 0);
      wr(HLCR_A_XL_RESP, HLCR_RESP_RECYCLE);
      wr(HLCR_A_XL_DELAY, 16'h0002);
      exch_temp_i = 16'h0320;
      wait_state(1, 0);
      exch_temp_i = 16'h02bc;
      wait_state(0, 0);
      `CHK("wait len", 1'b1, n >= 2 * CPS - 1 && n <= 2 * CPS + 2)
      wr(HLCR_A_XL_RESP, HLCR_RESP_RETRY);
      wr(HLCR_A_XL_RETRY, 16'h0001);
      exch_temp_i = 16'h0320;
      wait_state(1, 0);
      wait_state(0, 1);
      `CHK("retry count", 16'h0001, exch_retry_count_o)
      wr(HLCR_A_XL_RESP, HLCR_RESP_RECYCLE);
      wr(HLCR_A_XL_DELAY, HLCR_NOT_CONFIG);
      lockout_reset_i = 1'b1;
      cyc(1);
      lockout_reset_i = 1'b0;
      wait_state(0, 1);
      `CHK("no wait", 16'h0000, exch_retry_count_o)
      wr(HLCR_A_XL_ENABLE, 16'h0000);
      lockout_reset_i = 1'b1;
      cyc(1);
      lockout_reset_i = 1'b0;
      cyc(4);
      `CHK("trip off", 1'b0, exch_trip_o)
      `CHK("idle", 1'b0, exch_lockout_o)
      // Reset in mid-run restores the register contents
      rst_i = 1'b1;
      cyc(2);
      rst_i = 1'b0;
      rd(HLCR_A_SRC_SEL, HLCR_RST[HLCR_I_SRC_SEL], 1);
      rd(HLCR_A_XL_RETRY, HLCR_RST[HLCR_I_XL_RETRY], 1);
      complete_run();
   end
endmodule // hlcr_top_bench
